//--- rtl/vic_ctrl.sv
/*
  vectored priority interrupt controller: arbitration, vector fetch, entry/return stack.
  assumes the core supplies its pc, a return pulse and an instruction-retire pulse,
  and answers a vector fetch with the 24-bit word in the following cycle.
*/
`timescale 1ns/1ps
module vic_ctrl (
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire logic [5:0]            regAddr,
  input  wire logic [15:0]           regWdata,
  input  wire logic                  regWr,
  input  wire logic                  regRd,
  output logic [15:0]                regRdata,
  input  wire logic [31:0]           srcIrq,
  input  wire logic [7:0]            trapIrq,
  input  wire logic [23:0]           curPc,
  input  wire logic                  retPulse,
  input  wire logic                  instrRetire,
  output logic                       irqReq,
  output logic                       fetchRd,
  output logic [23:0]                fetchAddr,
  input  wire logic [23:0]           fetchData,
  output vic_pkg::vic_redirect_t     redirect,
  output logic [7:0]                 cpuSrl
);
  // ==========================================================================
  // state
  // fixed walk through the states keeps entry latency the same every time
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_FETCH = 3'b010,
    ST_LOAD  = 3'b100
  } vic_state_t;

  vic_state_t             state_r, state_nxt;
  logic [15:0]            ctrl1_r, ctrl2_r, flag1_r, flag2_r, en1_r, en2_r;
  logic [15:0]            prio_r [vic_pkg::NUM_PRIO_REGS];
  logic [7:0]             srl_r;
  logic [13:0]            tdisCnt_r;
  logic [3:0]             depth_r;
  logic [23:0]            stackPc [vic_pkg::STACK_DEPTH];
  logic [7:0]             stackSrl [vic_pkg::STACK_DEPTH];
  vic_pkg::vic_win_t      take_r;
  logic [23:0]            fetchAddr_r;
  vic_pkg::vic_redirect_t redirect_r;
  logic [15:0]            rdata_r;

  function automatic logic [2:0] userLevel(input logic [15:0] pr [vic_pkg::NUM_PRIO_REGS],
                                           input int k);
    logic [15:0] word;
    word = pr[k / 4];
    return word[(k % 4) * 4 +: 3];
  endfunction : userLevel

  // ==========================================================================
  // register decode
  wire        wrCtrl1 = regWr && regAddr == vic_pkg::REG_CTRL1;
  wire        wrCtrl2 = regWr && regAddr == vic_pkg::REG_CTRL2;
  wire        wrFlag1 = regWr && regAddr == vic_pkg::REG_FLAG1;
  wire        wrFlag2 = regWr && regAddr == vic_pkg::REG_FLAG2;
  wire        wrEn1   = regWr && regAddr == vic_pkg::REG_EN1;
  wire        wrEn2   = regWr && regAddr == vic_pkg::REG_EN2;
  wire        wrSrl   = regWr && regAddr == vic_pkg::REG_SRL;
  wire        wrTdis  = regWr && regAddr == vic_pkg::REG_TDIS;
  wire        prioHit = regAddr >= vic_pkg::REG_PRIO0 && regAddr < vic_pkg::REG_SRL;
  wire [2:0]  prioIdx = 3'(regAddr - vic_pkg::REG_PRIO0);

  wire [2:0]  cpuPrio = srl_r[vic_pkg::SRL_PRIO_LSB +: 3];
  wire        nestDis = ctrl1_r[vic_pkg::NEST_DIS_BIT];
  wire        altSel  = ctrl2_r[vic_pkg::ALT_SEL_BIT];
  wire [31:0] pendUser = {flag2_r & en2_r, flag1_r & en1_r};
  wire [7:0]  trapFlags = ctrl1_r[7:0];
  wire [23:0] tableBase = altSel ? vic_pkg::ALT_BASE : vic_pkg::PRIMARY_BASE;
  wire        idle    = state_r == ST_IDLE;
  wire        doRet   = idle && retPulse && depth_r != 4'h0;
  wire [3:0]  topIdx  = depth_r - 4'h1;
  wire [23:0] topPc   = stackPc[topIdx[2:0]];
  wire [7:0]  topSrl  = stackSrl[topIdx[2:0]];

  // ==========================================================================
  // arbitration: scanning downward with >= leaves the lowest vector on ties
  vic_pkg::vic_win_t win;
  always_comb begin
    logic [3:0] lvl;
    logic       ok;
    lvl = 4'h0;
    ok  = 1'b0;
    win = '0;
    for (int k = vic_pkg::NUM_USER - 1; k >= 0; k--) begin
      lvl = {1'b0, userLevel(prio_r, k)};
      ok  = pendUser[k] && lvl != 4'h0;
      if (tdisCnt_r != 14'h0 && lvl <= vic_pkg::TDIS_TOP_LVL) begin
        ok = 1'b0;
      end
      if (nestDis && depth_r != 4'h0) begin
        ok = 1'b0;
      end
      if (ok && lvl >= win.level) begin
        win.valid = 1'b1;
        win.level = lvl;
        win.vec   = 6'(vic_pkg::NUM_TRAPS + k);
      end
    end
    // traps scanned last: any trap overrides a user winner, trap 0 ends on top
    for (int t = vic_pkg::NUM_TRAPS - 1; t >= 0; t--) begin
      if (trapFlags[t]) begin
        win.valid = 1'b1;
        win.level = vic_pkg::TRAP_TOP_LVL - 4'(t);
        win.vec   = 6'(t);
      end
    end
  end

  // a user level never exceeds 7, so priority 7 masks every user source
  assign irqReq = win.valid && win.level > {1'b0, cpuPrio};

  // ==========================================================================
  // entry and return sequencer, fixed three-cycle entry and one-cycle return
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (irqReq && !doRet) begin
          state_nxt = ST_FETCH;
        end
      end
      ST_FETCH: state_nxt = ST_LOAD;
      ST_LOAD:  state_nxt = ST_IDLE;
      default:  state_nxt = ST_IDLE;
    endcase
  end

  // a return beats a fresh take so the restored priority is judged first
  wire        startEntry = idle && irqReq && !doRet;
  wire        pushNow    = state_r == ST_LOAD;
  wire [23:0] vecAddr    = tableBase + {17'h0, win.vec, 1'b0};

  assign fetchRd   = state_r == ST_FETCH;
  assign fetchAddr = fetchAddr_r;
  assign redirect  = redirect_r;
  assign cpuSrl    = srl_r;
  assign regRdata  = rdata_r;

  vic_pkg::vic_redirect_t redirect_nxt;
  assign redirect_nxt.valid = pushNow || doRet;
  assign redirect_nxt.addr  = pushNow ? fetchData : (doRet ? topPc : 24'h0);

  wire [7:0] srlEntry = (srl_r & ~vic_pkg::SRL_PRIO_OR) |
                        {(take_r.level > vic_pkg::USER_TOP_LVL) ? 3'h7 : take_r.level[2:0],
                         5'h00};
  wire [7:0] srl_nxt  = pushNow ? srlEntry :
                        doRet   ? topSrl   :
                        wrSrl   ? regWdata[7:0] : srl_r;

  // ==========================================================================
  // flags: hardware set wins over a software clear in the same cycle
  wire [15:0] flag1_nxt = (wrFlag1 ? regWdata : flag1_r) | srcIrq[15:0];
  wire [15:0] flag2_nxt = ((wrFlag2 ? regWdata : flag2_r) | srcIrq[31:16]) & vic_pkg::EN2_MASK;
  wire [15:0] ctrl1_nxt = (wrCtrl1 ? regWdata : ctrl1_r) | {8'h00, trapIrq};
  // a fresh load wins over a retire in the same cycle
  wire [13:0] tdis_nxt  = wrTdis ? regWdata[13:0] :
                          (instrRetire && tdisCnt_r != 14'h0) ? tdisCnt_r - 14'h1 :
                          tdisCnt_r;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r     <= ST_IDLE;
      ctrl1_r     <= 16'h0000;
      ctrl2_r     <= 16'h0000;
      flag1_r     <= 16'h0000;
      flag2_r     <= 16'h0000;
      en1_r       <= 16'h0000;
      en2_r       <= 16'h0000;
      srl_r       <= 8'h00;
      tdisCnt_r   <= 14'h0000;
      depth_r     <= 4'h0;
      take_r      <= '0;
      fetchAddr_r <= vic_pkg::RESET_PC;
      redirect_r  <= '0;
    end else begin
      state_r     <= state_nxt;
      ctrl1_r     <= ctrl1_nxt;
      ctrl2_r     <= wrCtrl2 ? regWdata : ctrl2_r;
      flag1_r     <= flag1_nxt;
      flag2_r     <= flag2_nxt;
      en1_r       <= wrEn1 ? (regWdata & vic_pkg::EN1_MASK) : en1_r;
      en2_r       <= wrEn2 ? (regWdata & vic_pkg::EN2_MASK) : en2_r;
      srl_r       <= srl_nxt;
      tdisCnt_r   <= tdis_nxt;
      redirect_r  <= redirect_nxt;
      if (startEntry) begin
        take_r      <= win;
        fetchAddr_r <= vecAddr;
      end
      if (pushNow && depth_r != 4'(vic_pkg::STACK_DEPTH)) begin
        depth_r <= depth_r + 4'h1;
      end else if (doRet) begin
        depth_r <= depth_r - 4'h1;
      end
    end
  end

  // ==========================================================================
  // priority fields: reset level 4 on every source
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < vic_pkg::NUM_PRIO_REGS; i++) begin
        prio_r[i] <= vic_pkg::PRIO_RESET;
      end
    end else if (regWr && prioHit) begin
      prio_r[prioIdx] <= regWdata & vic_pkg::PRIO_MASK;
    end
  end

  // ==========================================================================
  // return stack; a push beyond the depth is dropped, so that return is lost
  always_ff @(posedge mclk) begin
    if (pushNow && depth_r != 4'(vic_pkg::STACK_DEPTH)) begin
      stackPc[depth_r[2:0]]  <= curPc;
      stackSrl[depth_r[2:0]] <= srl_r;
    end
  end

  // ==========================================================================
  // read port
  logic [15:0] rdMux;
  always_comb begin
    rdMux = 16'h0000;
    case (regAddr)
      vic_pkg::REG_CTRL1: rdMux = ctrl1_r;
      vic_pkg::REG_CTRL2: rdMux = ctrl2_r;
      vic_pkg::REG_FLAG1: rdMux = flag1_r;
      vic_pkg::REG_FLAG2: rdMux = flag2_r;
      vic_pkg::REG_EN1:   rdMux = en1_r;
      vic_pkg::REG_EN2:   rdMux = en2_r;
      vic_pkg::REG_SRL:   rdMux = {8'h00, srl_r};
      vic_pkg::REG_TDIS:  rdMux = {2'b00, tdisCnt_r};
      vic_pkg::REG_STAT:  rdMux = {irqReq, 1'b0, depth_r, take_r.vec, take_r.level};
      default: begin
        if (prioHit) begin
          rdMux = prio_r[prioIdx];
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 16'h0000;
    end else begin
      // zero outside the answer cycle so a stale word never looks like a read
      rdata_r <= regRd ? rdMux : 16'h0000;
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_req_above_cpu: assert property (irqReq |-> win.level > {1'b0, cpuPrio})
    else $error("request raised at or below cpu priority");
  a_trap_never_masked: assert property (trapFlags != 8'h00 |-> irqReq)
    else $error("pending trap not requested");
  a_vector0_first: assert property (trapFlags[0] |-> win.vec == 6'h00)
    else $error("vector 0 did not win");
  a_entry_latency: assert property (startEntry |-> ##3 redirect.valid)
    else $error("entry latency wrong");
  a_return_restore: assert property (doRet |=> redirect.valid && redirect.addr == $past(topPc))
    else $error("return did not restore pc");
  a_alt_table_used: assert property (fetchRd && altSel |-> fetchAddr >= vic_pkg::ALT_BASE)
    else $error("alternate table not used");
  a_flag_sticky: assert property (srcIrq[0] |=> flag1_r[0] ##1
                                  (flag1_r[0] || $past(wrFlag1 && !regWdata[0])))
    else $error("source flag lost");
  a_tdis_blocks_low: assert property (tdisCnt_r != 14'h0 && trapFlags == 8'h00 && irqReq
                                      |-> win.level == vic_pkg::USER_TOP_LVL)
    else $error("timed disable let a low level through");
  a_nest_blocks_user: assert property (nestDis && depth_r != 4'h0 && trapFlags == 8'h00
                                       |-> !irqReq)
    else $error("nested user interrupt while disabled");
  a_en2_unimpl_zero: assert property ((en2_r & ~vic_pkg::EN2_MASK) == 16'h0000)
    else $error("unimplemented enable bit set");

  // ==========================================================================
  // entry, return and register checks
  a_tdis_countdown: assert property (instrRetire && tdisCnt_r != 14'h0 && !wrTdis
                                     |=> tdisCnt_r == $past(tdisCnt_r) - 14'h1)
    else $error("timed disable count did not step down");
  a_tdis_load: assert property (wrTdis |=> tdisCnt_r == $past(regWdata[13:0]))
    else $error("timed disable count not loaded");
  a_ret_srl_restore: assert property (doRet |=> cpuSrl == $past(topSrl))
    else $error("return did not restore status byte");
  a_ret_depth: assert property (doRet |=> depth_r == $past(depth_r) - 4'h1)
    else $error("return did not pop the stack");
  a_trap_entry_prio: assert property (pushNow && take_r.level > vic_pkg::USER_TOP_LVL
                                      |=> cpuPrio == 3'h7)
    else $error("trap entry did not raise cpu priority to 7");
  a_fetch_one_cycle: assert property (startEntry |=> fetchRd ##1 !fetchRd)
    else $error("vector fetch did not stand one cycle");
  a_level0_silent: assert property (win.valid && trapFlags == 8'h00 |-> win.level != 4'h0)
    else $error("level 0 source won arbitration");
  a_stack_full_hold: assert property (pushNow && depth_r == 4'(vic_pkg::STACK_DEPTH)
                                      |=> depth_r == 4'(vic_pkg::STACK_DEPTH))
    else $error("stack depth moved past full");
  a_ret_beats_take: assert property (doRet |=> state_r == ST_IDLE)
    else $error("entry started on a return edge");
  a_primary_used: assert property (fetchRd && !altSel |-> fetchAddr < vic_pkg::ALT_BASE)
    else $error("primary table fetch outside its table");
  a_en1_write: assert property (wrEn1 |=> en1_r == ($past(regWdata) & vic_pkg::EN1_MASK))
    else $error("enable group 1 write lost");
  a_en2_write: assert property (wrEn2 |=> en2_r == ($past(regWdata) & vic_pkg::EN2_MASK))
    else $error("enable group 2 write lost");

  c_entry:  cover property (startEntry ##3 redirect.valid);
  c_return: cover property (doRet);
  c_nested: cover property (pushNow && depth_r == 4'h1);
  c_alt:    cover property (fetchRd && altSel);
  c_tdis:   cover property (tdisCnt_r != 14'h0 && pendUser != 32'h0 && !irqReq);
endmodule : vic_ctrl

//--- pkg/vic_pkg.sv
/*
  constants, register map and carrier types of the vectored interrupt controller.
  assumes a 16-bit register port and a core that fetches vector words for this block.
*/
package vic_pkg;
  // ==========================================================================
  // sizes
  localparam int          NUM_TRAPS   = 8;
  localparam int          NUM_USER    = 32;
  localparam int          NUM_VEC     = NUM_TRAPS + NUM_USER;
  localparam int          TABLE_VECS  = 126;
  localparam int          STACK_DEPTH = 8;
  localparam int          ADDR_W      = 6;
  localparam int          DATA_W      = 16;
  localparam int          PC_W        = 24;
  // ==========================================================================
  // vector tables, program addresses step by two per entry
  localparam logic [23:0] PRIMARY_BASE = 24'h000004;
  localparam logic [23:0] ALT_BASE     = PRIMARY_BASE + 24'(2 * TABLE_VECS);
  localparam logic [23:0] RESET_PC     = 24'h000000;
  // ==========================================================================
  // register indexes
  localparam logic [5:0]  REG_CTRL1 = 6'h00;
  localparam logic [5:0]  REG_CTRL2 = 6'h01;
  localparam logic [5:0]  REG_FLAG1 = 6'h02;
  localparam logic [5:0]  REG_FLAG2 = 6'h03;
  localparam logic [5:0]  REG_EN1   = 6'h04;
  localparam logic [5:0]  REG_EN2   = 6'h05;
  localparam logic [5:0]  REG_PRIO0 = 6'h06;
  localparam logic [5:0]  REG_SRL   = 6'h0e;
  localparam logic [5:0]  REG_TDIS  = 6'h0f;
  localparam logic [5:0]  REG_STAT  = 6'h10;
  localparam int          NUM_PRIO_REGS = 8;
  // ==========================================================================
  // fields
  localparam int          NEST_DIS_BIT  = 15;
  localparam int          ALT_SEL_BIT   = 15;
  localparam int          SRL_PRIO_LSB  = 5;
  localparam logic [15:0] EN1_MASK      = 16'hffff;
  localparam logic [15:0] EN2_MASK      = 16'h4066;
  localparam logic [15:0] PRIO_MASK     = 16'h7777;
  localparam logic [15:0] PRIO_RESET    = 16'h4444;
  localparam logic [7:0]  SRL_PRIO_OR   = 8'he0;
  localparam logic [3:0]  TRAP_TOP_LVL  = 4'hf;
  localparam logic [3:0]  USER_TOP_LVL  = 4'h7;
  localparam logic [3:0]  TDIS_TOP_LVL  = 4'h6;

  typedef struct packed {
    logic       valid;
    logic [3:0] level;
    logic [5:0] vec;
  } vic_win_t;

  typedef struct packed {
    logic        valid;
    logic [23:0] addr;
  } vic_redirect_t;
endpackage : vic_pkg

//--- verification/vic_core_model.sv
/*
  core stand-in: answers vector fetches, holds the pc, passes return and retire pulses.
  assumes the fetch and redirect timing of the controller's hand-over.
*/
`timescale 1ns/1ps
module vic_core_model (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              fetchRd,
  input  wire logic [23:0]       fetchAddr,
  input  vic_pkg::vic_redirect_t redirect,
  input  wire logic              doRet,
  input  wire logic              doRetire,
  output logic [23:0]            fetchData,
  output logic [23:0]            curPc,
  output logic                   retPulse,
  output logic                   instrRetire
);
  // ==========================================================================
  // fetch answer and pc
  // word stands one cycle only; after that each cycle inverts the last value, so the word shows again every second cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fetchData <= 24'h000000;
      curPc     <= 24'h000200;
    end else begin
      fetchData <= fetchRd ? (fetchAddr | 24'h100000) : ~fetchData;
      curPc     <= redirect.valid ? redirect.addr : curPc;
    end
  end
  assign retPulse    = doRet;
  assign instrRetire = doRetire;
endmodule : vic_core_model

//--- verification/vic_ctrl_tb_top.sv
/*
  bench for the interrupt controller: register port, entry, return, masking.
  assumes vic_core_model as the core and resets the controller before each scenario.
*/
`timescale 1ns/1ps
module vic_ctrl_tb_top;
  logic                   mclk, rst_n, regWr, regRd, retPulse, instrRetire;
  logic                   irqReq, fetchRd, doRet, doRetire;
  logic [5:0]             regAddr;
  logic [15:0]            regWdata, regRdata;
  logic [31:0]            srcIrq;
  logic [7:0]             trapIrq, cpuSrl;
  logic [23:0]            curPc, fetchAddr, fetchData, va;
  vic_pkg::vic_redirect_t redirect;
  int                     n_fail, cmp_count, lat;

  vic_ctrl i_dut (.mclk, .rst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .srcIrq, .trapIrq, .curPc, .retPulse, .instrRetire, .irqReq, .fetchRd,
    .fetchAddr, .fetchData, .redirect, .cpuSrl);
  vic_core_model i_core (.mclk, .rst_n, .fetchRd, .fetchAddr, .redirect, .doRet,
    .doRetire, .fetchData, .curPc, .retPulse, .instrRetire);

  // ==========================================================================
  // shared tasks
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic results();
    if (n_fail == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  task automatic reset();
    @(posedge mclk) rst_n <= 1'b0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
  endtask : reset
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : idle
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge mclk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge mclk) regWr <= 1'b0;
  endtask : wr
  task automatic rdChk(input logic [5:0] a, input logic [15:0] e, input string nm);
    @(posedge mclk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge mclk) regRd <= 1'b0;
    #1;
    chk(nm, {8'h00, e}, {8'h00, regRdata});
  endtask : rdChk
  task automatic pulse(input logic [31:0] s, input logic [7:0] t);
    @(posedge mclk);
    srcIrq  <= s;
    trapIrq <= t;
    @(posedge mclk);
    srcIrq  <= 32'h0;
    trapIrq <= 8'h00;
  endtask : pulse
  // bounded wait; lat counts edges until the redirect pulse shows
  task automatic waitRedir();
    lat = 0;
    #1;
    while (redirect.valid !== 1'b1 && lat < 40) begin
      @(posedge mclk);
      #1;
      lat++;
    end
    va = redirect.addr;
    if (lat >= 40) begin
      n_fail++;
      results();
    end
  endtask : waitRedir
  task automatic ret();
    @(posedge mclk) doRet <= 1'b1;
    @(posedge mclk) doRet <= 1'b0;
    waitRedir();
  endtask : ret
  task automatic retire(input int n);
    repeat (n) begin
      @(posedge mclk) doRetire <= 1'b1;
      @(posedge mclk) doRetire <= 1'b0;
    end
  endtask : retire

  // ==========================================================================
  // scenarios
  task automatic t_regs();
    reset();
    chk("redirect", 24'h0, redirect.addr);
    rdChk(vic_pkg::REG_PRIO0, 16'h4444, "prio0");
    chk("srl", 24'h0, {16'h0, cpuSrl});
    wr(vic_pkg::REG_EN2, 16'hffff);
    rdChk(vic_pkg::REG_EN2, 16'h4066, "en2");
    wr(vic_pkg::REG_EN1, 16'hffff);
    rdChk(vic_pkg::REG_EN1, 16'hffff, "en1");
    rdChk(6'h3f, 16'h0000, "unmapped");
  endtask : t_regs
  task automatic t_entry();
    reset();
    wr(vic_pkg::REG_FLAG1, 16'h0000);
    wr(vic_pkg::REG_EN1, 16'h0001);
    pulse(32'h1, 8'h00);
    waitRedir();
    chk("entry lat", 24'd3, 24'(lat));
    chk("fetch", vic_pkg::PRIMARY_BASE + 24'h10, fetchAddr);
    chk("handler", 24'h100014, va);
    chk("prio", 24'd4, {21'h0, cpuSrl[7:5]});
    rdChk(vic_pkg::REG_STAT, 16'h0484, "status");
    ret();
    chk("ret lat", 24'd0, 24'(lat));
    chk("ret pc", 24'h000200, va);
    chk("ret srl", 24'h0, {16'h0, cpuSrl});
    idle(1);
    waitRedir();
    chk("reentry", 24'h100014, va);
    wr(vic_pkg::REG_FLAG1, 16'h0000);
    ret();
    idle(3);
    chk("no reentry", 24'h0, {23'h0, irqReq});
  endtask : t_entry
  task automatic t_trap();
    reset();
    wr(vic_pkg::REG_EN1, 16'h0001);
    wr(vic_pkg::REG_SRL, 16'h00e0);
    pulse(32'h1, 8'h00);
    idle(3);
    chk("masked", 24'h0, fetchAddr);
    wr(vic_pkg::REG_CTRL2, 16'h8000);
    pulse(32'h0, 8'h02);
    waitRedir();
    chk("alt fetch", 24'h000102, fetchAddr);
    chk("trap prio", 24'd7, {21'h0, cpuSrl[7:5]});
    idle(1);
    waitRedir();
    chk("trap again", 24'h100102, va);
    rdChk(vic_pkg::REG_CTRL1, 16'h0002, "trap flag");
  endtask : t_trap
  task automatic t_order();
    reset();
    wr(vic_pkg::REG_EN1, 16'h000e);
    wr(vic_pkg::REG_PRIO0, 16'h0444);
    pulse(32'h8, 8'h00);
    idle(2);
    chk("level0", 24'h0, {23'h0, irqReq});
    pulse(32'h6, 8'h00);
    waitRedir();
    chk("order", vic_pkg::PRIMARY_BASE + 24'h12, fetchAddr);
    idle(2);
    chk("equal lvl", 24'h0, {23'h0, irqReq});
  endtask : t_order
  task automatic t_tdis();
    reset();
    wr(vic_pkg::REG_PRIO0, 16'h4447);
    wr(vic_pkg::REG_EN1, 16'h0003);
    wr(vic_pkg::REG_TDIS, 16'h0002);
    pulse(32'h2, 8'h00);
    idle(3);
    chk("tdis block", 24'h0, fetchAddr);
    pulse(32'h1, 8'h00);
    waitRedir();
    chk("lvl7 pass", 24'h100014, va);
    wr(vic_pkg::REG_FLAG1, 16'h0002);
    ret();
    retire(1);
    idle(3);
    chk("tdis held", 24'h000014, fetchAddr);
    retire(1);
    waitRedir();
    chk("tdis end", 24'h100016, va);
  endtask : t_tdis
  task automatic t_nest();
    reset();
    wr(vic_pkg::REG_CTRL1, 16'h8000);
    wr(vic_pkg::REG_PRIO0, 16'h4441);
    wr(vic_pkg::REG_EN1, 16'h0003);
    pulse(32'h1, 8'h00);
    waitRedir();
    pulse(32'h2, 8'h00);
    idle(4);
    chk("no preempt", 24'h000014, fetchAddr);
    wr(vic_pkg::REG_FLAG1, 16'h0002);
    ret();
    idle(1);
    waitRedir();
    chk("after nest", 24'h100016, va);
  endtask : t_nest

  // ==========================================================================
  // clock and main sequence
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    {n_fail, cmp_count, lat} = '0;
    {rst_n, regWr, regRd, doRet, doRetire} = '0;
    {regAddr, regWdata, srcIrq, trapIrq} = '0;
    t_regs();
    t_entry();
    t_trap();
    t_order();
    t_tdis();
    t_nest();
    results();
  end
endmodule : vic_ctrl_tb_top
